// *** src/hwr_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module hwr_ctrl #(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core side
  input wire hwr_pkg::hwr_core_req_t core_req,
  input wire logic stack_full,
  output logic core_stall,
  output logic resume_next,
  output logic resume_vector,
  // wake sources
  input wire logic external_reset_pin_n,
  input wire logic wdt_overflow,
  input wire logic [PORT_W-1:0] port_a_in,
  input wire logic [IRQ_W-1:0] irq_flags,
  input wire logic [IRQ_W-1:0] irq_enable,
  input wire logic irq_master_en,
  // clocks and resets out
  output logic sys_osc_run,
  output logic wdt_osc_run,
  output logic lcd_run,
  output logic hold_state,
  output hwr_pkg::hwr_rst_out_t rst_out,
  output logic [10:0] pc_reset_value,
  output logic watchdog_timeout_flag,
  output logic power_down_flag
);
  import hwr_pkg::*;

  typedef enum logic [1:0] {
    HWR_ST_POWERUP, HWR_ST_RUN, HWR_ST_HALT, HWR_ST_WAKE
  } hwr_state_t;

  hwr_state_t state_q;
  logic [4:0] ctrl_q;
  logic [PORT_W-1:0] wake_mask_q;
  logic [PORT_W-1:0] port_prev_q;
  logic [IRQ_W-1:0] irq_arm_q;
  logic watchdog_timeout_flag_q, power_down_flag_q;
  logic resume_vec_q;
  hwr_cause_t cause_q;
  logic [1:0] wsrc;
  logic rtc_sys, osc_restart, osc_run_q;
  logic ext_rst, port_wake, irq_wake, halt_wdt, any_wake, wdt_run_rst;
  logic sst_start, sst_busy, sst_done;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_fire;

  assign wsrc = ctrl_q[HWR_CTRL_CLKSEL_LO +: 2];
  assign rtc_sys = ctrl_q[HWR_CTRL_RTC_SYS];
  assign ext_rst = !external_reset_pin_n;
  // port a wake only on falling edges of enabled pins
  assign port_wake = |(port_prev_q & ~port_a_in & wake_mask_q);
  // flags pending at halt entry are disarmed
  assign irq_wake = |(irq_flags & irq_arm_q);
  assign halt_wdt = wdt_overflow && ctrl_q[HWR_CTRL_WDT_EN] &&
                    (wsrc != HWR_WSRC_INSTR);
  assign any_wake = (state_q == HWR_ST_HALT) &&
                    (ext_rst || port_wake || irq_wake || halt_wdt);
  assign wdt_run_rst = (state_q == HWR_ST_RUN) && wdt_overflow &&
                       ctrl_q[HWR_CTRL_WDT_EN];
  assign sst_start = any_wake || (state_q == HWR_ST_POWERUP && !osc_run_q);
  assign osc_restart = (state_q != HWR_ST_HALT) || rtc_sys;

  hwr_sst u_sst (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(sst_start),
    .osc_run(osc_run_q),
    .busy(sst_busy),
    .done(sst_done)
  );

  // sequencer state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= HWR_ST_POWERUP;
    end else begin
      case (state_q)
        HWR_ST_POWERUP: if (sst_done) state_q <= HWR_ST_RUN;
        HWR_ST_RUN: if (core_req.halt && !ext_rst && !wdt_run_rst)
          state_q <= HWR_ST_HALT;
        HWR_ST_HALT: if (any_wake) state_q <= HWR_ST_WAKE;
        HWR_ST_WAKE: if (sst_done) state_q <= HWR_ST_RUN;
        default: state_q <= HWR_ST_POWERUP;
      endcase
    end
  end

  // oscillator running; restarts once wake begins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_run_q <= 1'b0;
    end else begin
      osc_run_q <= osc_restart || any_wake;
    end
  end

  // halt entry arms only interrupts not already pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_arm_q <= '0;
      port_prev_q <= '1;
    end else begin
      port_prev_q <= port_a_in;
      if (state_q == HWR_ST_RUN && core_req.halt) begin
        irq_arm_q <= ~irq_flags;
      end else if (state_q != HWR_ST_HALT) begin
        irq_arm_q <= '0;
      end
    end
  end

  // reset-cause flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_timeout_flag_q <= 1'b0;
      power_down_flag_q <= 1'b0;
    end else if (state_q == HWR_ST_RUN && core_req.halt && !ext_rst &&
                 !wdt_run_rst) begin
      power_down_flag_q <= 1'b1;
      watchdog_timeout_flag_q <= 1'b0;
    end else if (state_q == HWR_ST_HALT && ext_rst) begin
      watchdog_timeout_flag_q <= 1'b0;
      power_down_flag_q <= 1'b1;
    end else if (wdt_run_rst || (state_q == HWR_ST_HALT && halt_wdt)) begin
      watchdog_timeout_flag_q <= 1'b1;
    end else if (core_req.wdt_clear && state_q == HWR_ST_RUN) begin
      power_down_flag_q <= 1'b0;
    end
  end

  // cause and interrupt vectoring decision
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cause_q <= HWR_CAUSE_POWERUP;
      resume_vec_q <= 1'b0;
    end else if (any_wake) begin
      resume_vec_q <= 1'b0;
      if (ext_rst) begin
        cause_q <= HWR_CAUSE_EXT_HALT;
      end else if (halt_wdt) begin
        cause_q <= HWR_CAUSE_WDT_HALT;
      end else if (irq_wake) begin
        cause_q <= HWR_CAUSE_IRQ;
        resume_vec_q <= irq_master_en && !stack_full &&
                        |(irq_flags & irq_arm_q & irq_enable);
      end else begin
        cause_q <= HWR_CAUSE_PORT;
      end
    end else if (state_q == HWR_ST_RUN && ext_rst) begin
      cause_q <= HWR_CAUSE_EXT_RUN;
    end else if (wdt_run_rst) begin
      cause_q <= HWR_CAUSE_WDT_RUN;
    end
  end

  // reset actions, one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_out <= '0;
    end else begin
      rst_out.full_reset <= ((state_q == HWR_ST_RUN) &&
                             (ext_rst || wdt_run_rst)) ||
                            (any_wake && ext_rst);
      rst_out.warm_reset <= any_wake && halt_wdt && !ext_rst;
      rst_out.wdt_restart <= (state_q == HWR_ST_RUN && core_req.halt &&
                              wsrc != HWR_WSRC_INSTR) ||
                             (core_req.wdt_clear && state_q == HWR_ST_RUN);
    end
  end

  assign core_stall = (state_q != HWR_ST_RUN) || sst_busy;
  assign resume_next = sst_done && state_q == HWR_ST_WAKE &&
                       !resume_vec_q;
  assign resume_vector = sst_done && state_q == HWR_ST_WAKE &&
                         resume_vec_q;
  assign sys_osc_run = osc_run_q;
  assign wdt_osc_run = (state_q != HWR_ST_HALT) ||
                       (wsrc != HWR_WSRC_INSTR);
  assign lcd_run = ctrl_q[HWR_CTRL_LCD_EN] && ((state_q != HWR_ST_HALT) ||
                   (wsrc != HWR_WSRC_INSTR));
  assign hold_state = state_q == HWR_ST_HALT;
  assign pc_reset_value = HWR_PC_RESET;
  assign watchdog_timeout_flag = watchdog_timeout_flag_q;
  assign power_down_flag = power_down_flag_q;

  // ahb-lite: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_fire = hsel && hready && htrans == HWR_HTRANS_NONSEQ && !hwrite;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= hsel && hready && htrans == HWR_HTRANS_NONSEQ && hwrite;
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= HWR_CTRL_RST;
      wake_mask_q <= PORT_W'(HWR_WAKE_RST);
    end else if (wr_pend_q) begin
      if (wr_addr_q == HWR_CTRL_ADDR) begin
        ctrl_q <= hwdata[4:0];
      end else if (wr_addr_q == HWR_WAKE_ADDR) begin
        wake_mask_q <= hwdata[PORT_W-1:0];
      end
    end
  end

  // unmapped reads return zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (rd_fire) begin
      if (haddr == HWR_CTRL_ADDR) begin
        hrdata <= {27'h0, ctrl_q};
      end else if (haddr == HWR_STAT_ADDR) begin
        hrdata <= {24'h0, 1'b0, cause_q, state_q,
                   watchdog_timeout_flag_q, power_down_flag_q};
      end else if (haddr == HWR_WAKE_ADDR) begin
        hrdata <= {{(32-PORT_W){1'b0}}, wake_mask_q};
      end else begin
        hrdata <= '0;
      end
    end
  end

  // cycles spent in wake, counted apart from the start-up timer itself
  localparam logic [HWR_SST_W-1:0] WAKE_LAST = HWR_SST_W'(HWR_SST_CYCLES - 1);
  logic [HWR_SST_W-1:0] wake_cyc_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_cyc_q <= '0;
    end else if (state_q == HWR_ST_WAKE) begin
      wake_cyc_q <= wake_cyc_q + 1'b1;
    end else begin
      wake_cyc_q <= '0;
    end
  end

  // checks watch the sequencer from its ports, state and internal registers
  chk_halt_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_RUN && core_req.halt && !ext_rst && !wdt_run_rst)
    |=> (power_down_flag_q && !watchdog_timeout_flag_q))
    else $error("halt entry flags wrong");
  chk_wdt_to: assert property (@(posedge clk) disable iff (sys_rst)
    wdt_run_rst |=> watchdog_timeout_flag_q)
    else $error("timeout flag not set");
  chk_clr_pdf: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_RUN && core_req.wdt_clear && !core_req.halt &&
     !ext_rst && !wdt_run_rst) |=> !power_down_flag_q)
    else $error("power-down flag not cleared");
  chk_warm_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (any_wake && halt_wdt && !ext_rst) |=>
    (rst_out.warm_reset && !rst_out.full_reset &&
     watchdog_timeout_flag_q && power_down_flag_q))
    else $error("watchdog wake not warm");
  chk_ext_halt: assert property (@(posedge clk) disable iff (sys_rst)
    (any_wake && ext_rst) |=> (rst_out.full_reset &&
     !watchdog_timeout_flag_q && power_down_flag_q))
    else $error("reset wake flags wrong");
  chk_wake_stall: assert property (@(posedge clk) disable iff (sys_rst)
    any_wake |=> core_stall [*8])
    else $error("core resumed too early");
  chk_halt_osc: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_HALT && !rtc_sys && !any_wake) |=> !sys_osc_run)
    else $error("oscillator not stopped");
  // a falling edge on a masked pin alone must leave the core halted
  chk_mask_wake: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_HALT && !ext_rst && !halt_wdt && !irq_wake &&
     (port_prev_q & ~port_a_in & wake_mask_q) == '0) |=>
    (state_q == HWR_ST_HALT))
    else $error("masked pin woke the core");
  chk_port_wake: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_HALT && |(port_prev_q & ~port_a_in & wake_mask_q))
    |=> (state_q == HWR_ST_WAKE && core_stall))
    else $error("enabled pin did not wake");
  chk_pend_arm: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_RUN && core_req.halt) |=>
    ((irq_arm_q & $past(irq_flags)) == '0))
    else $error("pending interrupt left armed");
  chk_wdt_rearm: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_RUN && core_req.halt && wsrc != HWR_WSRC_INSTR)
    |=> rst_out.wdt_restart)
    else $error("watchdog not restarted at halt");
  chk_wake_len: assert property (@(posedge clk) disable iff (sys_rst)
    (resume_next || resume_vector) |->
    (wake_cyc_q == WAKE_LAST))
    else $error("start-up wait length wrong");
  chk_run_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == HWR_ST_RUN && ext_rst) |=> rst_out.full_reset)
    else $error("no chip reset");
  cov_port_wake: cover property (@(posedge clk) any_wake && port_wake);
  cov_irq_vec: cover property (@(posedge clk) resume_vector);
  cov_wdt_wake: cover property (@(posedge clk) rst_out.warm_reset);
  cov_resume: cover property (@(posedge clk) resume_next);
  cov_ext_halt: cover property (@(posedge clk) any_wake && ext_rst);
endmodule : hwr_ctrl
`default_nettype wire

// *** src/hwr_pkg.sv ***
package hwr_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] HWR_CTRL_ADDR = 8'h00;
  localparam logic [7:0] HWR_STAT_ADDR = 8'h04;
  localparam logic [7:0] HWR_WAKE_ADDR = 8'h08;
  // control register fields
  localparam int HWR_CTRL_CLKSEL_LO = 0;
  localparam int HWR_CTRL_RTC_SYS = 2;
  localparam int HWR_CTRL_WDT_EN = 3;
  localparam int HWR_CTRL_LCD_EN = 4;
  localparam logic [4:0] HWR_CTRL_RST = 5'h18;
  localparam logic [7:0] HWR_WAKE_RST = 8'h00;
  // watchdog clock source encodings
  localparam logic [1:0] HWR_WSRC_WDTOSC = 2'h0;
  localparam logic [1:0] HWR_WSRC_RTC = 2'h1;
  localparam logic [1:0] HWR_WSRC_INSTR = 2'h2;
  localparam logic [10:0] HWR_PC_RESET = 11'h000;
  // start-up delay
  localparam int HWR_SST_CYCLES = 1024;
  localparam int HWR_SST_W = 11;
  localparam logic [1:0] HWR_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    HWR_CAUSE_NONE, HWR_CAUSE_POWERUP, HWR_CAUSE_EXT_RUN,
    HWR_CAUSE_EXT_HALT, HWR_CAUSE_WDT_RUN, HWR_CAUSE_WDT_HALT,
    HWR_CAUSE_PORT, HWR_CAUSE_IRQ
  } hwr_cause_t;

  // requests from the core
  typedef struct packed {
    logic halt;
    logic wdt_clear;
  } hwr_core_req_t;

  // reset actions toward the rest of the chip
  typedef struct packed {
    logic full_reset;
    logic warm_reset;
    logic wdt_restart;
  } hwr_rst_out_t;
endpackage : hwr_pkg

// *** src/hwr_sst.sv ***
`timescale 1ns/1ns
`default_nettype none
module hwr_sst #(
  parameter int CYCLES = hwr_pkg::HWR_SST_CYCLES,
  parameter int W = hwr_pkg::HWR_SST_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic osc_run,
  output logic busy,
  output logic done
);
  import hwr_pkg::*;
  logic [W-1:0] cnt_q;
  logic busy_q;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  // counts only while the oscillator runs, so a stopped clock adds no credit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q <= '0;
    end else if (busy_q && osc_run) begin
      if (cnt_q == LAST) begin
        busy_q <= 1'b0;
      end
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign busy = busy_q || start;
  assign done = busy_q && osc_run && (cnt_q == LAST);
endmodule : hwr_sst
`default_nettype wire

// *** tb/hwr_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module hwr_core_model
  import hwr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // instructions the bench wants executed
  input wire logic want_halt,
  input wire logic want_clr,
  // block side
  input wire logic core_stall,
  output var hwr_pkg::hwr_core_req_t core_req
);
  // a stalled core executes nothing, so a request then is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_req <= '0;
    end else begin
      core_req.halt <= want_halt && !core_stall;
      core_req.wdt_clear <= want_clr && !core_stall;
    end
  end
endmodule : hwr_core_model
`default_nettype wire

// *** tb/tb_halt_wakeup_reset_control.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_halt_wakeup_reset_control;
  import hwr_pkg::*;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
  logic [7:0] haddr = '0, port_a = 8'hff;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rd;
  logic hreadyout, hresp, core_stall, resume_next, resume_vector;
  logic want_halt = 0, want_clr = 0, stack_full = 0;
  logic ext_rst_n = 1, wdt_ovf = 0, irq_men = 0;
  logic [4:0] irq_flags = '0, irq_en = '0;
  logic sys_osc, wdt_osc, lcd_run, hold_state, to_flag, pd_flag;
  logic [10:0] pc_rst;
  logic [4:0] ev;
  hwr_core_req_t core_req;
  hwr_rst_out_t rst_out;
  int n_mismatch = 0, tests_run = 0, n;
  int cnt[5] = '{default: 0};
  int c0[5];

  always #20 clk = ~clk;

  hwr_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .core_req(core_req), .stack_full(stack_full),
    .core_stall(core_stall), .resume_next(resume_next),
    .resume_vector(resume_vector), .external_reset_pin_n(ext_rst_n),
    .wdt_overflow(wdt_ovf), .port_a_in(port_a), .irq_flags(irq_flags),
    .irq_enable(irq_en), .irq_master_en(irq_men), .sys_osc_run(sys_osc),
    .wdt_osc_run(wdt_osc), .lcd_run(lcd_run), .hold_state(hold_state),
    .rst_out(rst_out), .pc_reset_value(pc_rst),
    .watchdog_timeout_flag(to_flag), .power_down_flag(pd_flag));

  hwr_core_model i_core (.clk(clk), .sys_rst(sys_rst),
    .want_halt(want_halt), .want_clr(want_clr), .core_stall(core_stall),
    .core_req(core_req));

  // pulse tally: 4 full, 3 warm, 2 restart, 1 resume next, 0 vector
  assign ev = {rst_out, resume_next, resume_vector};
  always @(negedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (ev[i] === 1'b1) begin
        cnt[i]++;
      end
    end
  end

  task conclude;
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HWR_HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  // bounded wait for the core to be let go; n is the cycles waited
  task automatic run_wait;
    n = 0;
    while (core_stall !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask : run_wait

  task automatic halt_now;
    @(posedge clk);
    want_halt <= 1'b1;
    @(posedge clk);
    want_halt <= 1'b0;
    repeat (3) @(negedge clk);
  endtask : halt_now

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) wdt_ovf <= 1'b1;
    else ext_rst_n <= 1'b0;
    @(posedge clk);
    wdt_ovf <= 1'b0;
    ext_rst_n <= 1'b1;
    // let registered flags and pulses settle and be tallied
    repeat (2) @(negedge clk);
  endtask : pulse

  task automatic t_power;
    @(negedge clk);
    chk("flags", 0, {to_flag, pd_flag});
    chk("stall", 1, core_stall);
    chk("pc", HWR_PC_RESET, pc_rst);
    chk("hresp", 0, hresp);
    run_wait();
    chk("sst", 1, n >= 1024 && n <= 1034);
    bus(0, HWR_CTRL_ADDR, 0);
    chk("ctrl", HWR_CTRL_RST, rd);
    bus(0, HWR_WAKE_ADDR, 0);
    chk("wake", HWR_WAKE_RST, rd);
    bus(1, 8'h0c, 32'hffffffff);
    bus(0, 8'h0c, 0);
    chk("unmapped", 0, rd);
  endtask : t_power

  task automatic t_halt(input logic [4:0] ctrl);
    logic wd;
    wd = ctrl[1:0] != HWR_WSRC_INSTR;
    bus(1, HWR_CTRL_ADDR, ctrl);
    bus(1, HWR_WAKE_ADDR, 32'h2);
    bus(0, HWR_CTRL_ADDR, 0);
    chk("ctrl_rb", ctrl, rd);
    c0 = cnt;
    halt_now();
    chk("osc", ctrl[2], sys_osc);
    if (wd) chk("wdosc", 1, wdt_osc);
    chk("lcd", wd & ctrl[4], lcd_run);
    chk("hold", 1, hold_state);
    chk("flags", 2'b01, {to_flag, pd_flag});
    chk("restart", c0[2] + wd, cnt[2]);
    @(posedge clk);
    port_a <= 8'hfe;
    repeat (20) @(negedge clk);
    chk("masked", 1, core_stall);
    @(posedge clk);
    port_a <= 8'hfc;
    run_wait();
    chk("wake_len", 1, n >= 1024 && n <= 1034);
    chk("next", c0[1] + 1, cnt[1]);
    chk("vec", c0[0], cnt[0]);
    @(posedge clk);
    port_a <= 8'hff;
  endtask : t_halt

  task automatic t_irq;
    @(posedge clk);
    irq_en <= 5'h1f;
    irq_men <= 1'b1;
    irq_flags <= 5'h01;
    c0 = cnt;
    halt_now();
    repeat (20) @(negedge clk);
    chk("pending", 1, core_stall);
    @(posedge clk);
    irq_flags <= 5'h03;
    run_wait();
    chk("vec", c0[0] + 1, cnt[0]);
    @(posedge clk);
    stack_full <= 1'b1;
    irq_flags <= 5'h00;
    halt_now();
    @(posedge clk);
    irq_flags <= 5'h04;
    run_wait();
    chk("next_full", c0[1] + 1, cnt[1]);
    @(posedge clk);
    stack_full <= 1'b0;
    irq_flags <= 5'h00;
  endtask : t_irq

  task automatic t_wdt;
    c0 = cnt;
    halt_now();
    pulse(0);
    run_wait();
    chk("warm", c0[3] + 1, cnt[3]);
    chk("no_full", c0[4], cnt[4]);
    bus(0, HWR_STAT_ADDR, 0);
    chk("stat", 2'b11, rd[1:0]);
    @(posedge clk);
    want_clr <= 1'b1;
    @(posedge clk);
    want_clr <= 1'b0;
    repeat (3) @(negedge clk);
    chk("pdf_clr", 0, pd_flag);
    chk("restart", c0[2] + 2, cnt[2]);
    pulse(0);
    run_wait();
    chk("to_run", 2'b10, {to_flag, pd_flag});
    chk("full_wdt", c0[4] + 1, cnt[4]);
  endtask : t_wdt

  task automatic t_ext;
    c0 = cnt;
    pulse(1);
    run_wait();
    chk("ext_run", 2'b10, {to_flag, pd_flag});
    chk("full_run", c0[4] + 1, cnt[4]);
    halt_now();
    pulse(1);
    run_wait();
    chk("ext_len", 1, n >= 1020 && n <= 1034);
    chk("ext_halt", 2'b01, {to_flag, pd_flag});
    chk("full_halt", c0[4] + 2, cnt[4]);
  endtask : t_ext

  // the longest path is under 15000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_power();
    t_halt(5'h18);
    t_halt(5'h19);
    t_halt(5'h1e);
    bus(1, HWR_CTRL_ADDR, HWR_CTRL_RST);
    t_irq();
    t_wdt();
    t_ext();
    conclude();
  end
endmodule : tb_halt_wakeup_reset_control
`default_nettype wire
